// *** hw/ocpr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ocpr_consts.svh"

module ocpr_top import ocpr_pkg::*; #(
	parameter int N_TMR = 3
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// free running timers
	input wire logic [N_TMR*16-1:0] tmr_count_in,
	input wire logic [N_TMR*16-1:0] tmr_peak_in,
	input wire logic [N_TMR-1:0] tmr_updown_in,
	input wire logic [N_TMR-1:0] tmr_down_in,
	input wire logic [N_TMR-1:0] tmr_tick_in,
	// channel outputs
	output logic [1:0] compare_output_out,
	output logic [1:0] irq_out
);

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic aph_r;
	logic wr_r;
	logic [7:0] adr_r;
	logic [31:0] hrdata_r;
	logic hready_r;
	logic [1:0] run_r;
	logic [1:0] ie_r;
	logic enh_r;
	logic lega_r;
	logic [1:0] legb_r;
	logic [3:0] tsel_r;
	logic [3:0] cbuf_r;
	logic [3:0] tbuf_r;
	logic [15:0] cmp_buf_r [2];
	logic [31:0] tbl_buf_r [2];
	logic [1:0] flag_r;
	logic [1:0] out_r;
	logic [1:0] irq_r;
	logic [1:0] mt;
	logic [31:0] rd_ctrl;
	logic [31:0] rd_mode;
	logic [31:0] rd_mux;
	logic hsize_unused;

	wire logic req = hsel_in & htrans_in[1] & hready_in;
	wire logic [7:0] aadr = haddr_in[7:0];
	wire logic wr_ctrl = aph_r & wr_r & (adr_r == `OCPR_OFS_CTRL);
	wire logic wr_mode = aph_r & wr_r & (adr_r == `OCPR_OFS_MODE);
	wire logic wr_cmp0 = aph_r & wr_r & (adr_r == `OCPR_OFS_CMP0);
	wire logic wr_cmp1 = aph_r & wr_r & (adr_r == `OCPR_OFS_CMP1);
	wire logic wr_tbl0 = aph_r & wr_r & (adr_r == `OCPR_OFS_TBL0);
	wire logic wr_tbl1 = aph_r & wr_r & (adr_r == `OCPR_OFS_TBL1);

	assign hsize_unused = |hsize_in;

	// read data assembly; output level reads the live pin level
	always_comb begin
		rd_ctrl = 32'h0;
		rd_ctrl[`OCPR_CTRL_RUN +: 2] = run_r;
		rd_ctrl[`OCPR_CTRL_IE +: 2] = ie_r;
		rd_ctrl[`OCPR_CTRL_FLAG +: 2] = flag_r;
		rd_mode = 32'h0;
		rd_mode[`OCPR_MODE_ENH] = enh_r;
		rd_mode[`OCPR_MODE_LEGA] = lega_r;
		rd_mode[`OCPR_MODE_LEGB +: 2] = legb_r;
		rd_mode[`OCPR_MODE_OUT +: 2] = out_r;
		rd_mode[`OCPR_MODE_TSEL +: 4] = tsel_r;
		rd_mode[`OCPR_MODE_CBUF +: 4] = cbuf_r;
		rd_mode[`OCPR_MODE_TBUF +: 4] = tbuf_r;
	end

	// read selection, unmapped reads return zero
	assign rd_mux = (aadr == `OCPR_OFS_CTRL) ? rd_ctrl :
		(aadr == `OCPR_OFS_MODE) ? rd_mode :
		(aadr == `OCPR_OFS_CMP0) ? {16'h0, cmp_buf_r[0]} :
		(aadr == `OCPR_OFS_CMP1) ? {16'h0, cmp_buf_r[1]} :
		(aadr == `OCPR_OFS_TBL0) ? tbl_buf_r[0] :
		(aadr == `OCPR_OFS_TBL1) ? tbl_buf_r[1] : 32'h0;

	// address phase capture and zero wait answer
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			aph_r <= 1'b0;
			wr_r <= 1'b0;
			adr_r <= 8'h00;
			hrdata_r <= 32'h0;
			hready_r <= 1'b0;
		end else begin
			aph_r <= req;
			wr_r <= hwrite_in;
			adr_r <= aadr;
			hrdata_r <= (req & ~hwrite_in) ? rd_mux : 32'h0;
			hready_r <= 1'b1;
		end
	end

	// shared control registers; setting locks are left to software
	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			run_r <= 2'h0;
			ie_r <= 2'h0;
			enh_r <= `OCPR_RST_ENH;
			lega_r <= 1'b0;
			legb_r <= 2'h0;
			tsel_r <= 4'h0;
			cbuf_r <= 4'h0;
			tbuf_r <= 4'h0;
			cmp_buf_r[0] <= `OCPR_RST_CMP;
			cmp_buf_r[1] <= `OCPR_RST_CMP;
			tbl_buf_r[0] <= `OCPR_RST_TBL;
			tbl_buf_r[1] <= `OCPR_RST_TBL;
		end else begin
			if (wr_ctrl) begin
				run_r <= hwdata_in[`OCPR_CTRL_RUN +: 2];
				ie_r <= hwdata_in[`OCPR_CTRL_IE +: 2];
			end
			if (wr_mode) begin
				enh_r <= hwdata_in[`OCPR_MODE_ENH];
				lega_r <= hwdata_in[`OCPR_MODE_LEGA];
				legb_r <= hwdata_in[`OCPR_MODE_LEGB +: 2];
				tsel_r <= hwdata_in[`OCPR_MODE_TSEL +: 4];
				cbuf_r <= hwdata_in[`OCPR_MODE_CBUF +: 4];
				tbuf_r <= hwdata_in[`OCPR_MODE_TBUF +: 4];
			end
			if (wr_cmp0) cmp_buf_r[0] <= hwdata_in[15:0];
			if (wr_cmp1) cmp_buf_r[1] <= hwdata_in[15:0];
			if (wr_tbl0) tbl_buf_r[0] <= {16'h0, hwdata_in[15:0]};
			if (wr_tbl1) tbl_buf_r[1] <= hwdata_in;
		end
	end

	// ----------------------------------------------------------------
	// compare channels
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ch
			logic [15:0] cmp_act_r;
			logic [31:0] tbl_act_r;
			logic [1:0] sel;
			logic ok;
			logic [15:0] cnt;
			logic [15:0] pk;
			logic ud;
			logic tk;
			logic zero;
			logic peak;
			logic down;
			logic [1:0] cbm;
			logic [1:0] tbm;
			logic cxf;
			logic txf;
			logic [15:0] cuse;
			logic [31:0] tuse;
			logic [15:0] t16;
			logic [2:0] dec;
			logic act;
			logic clr;
			logic out_wr;
			logic out_nxt;
			logic flag_nxt;

			// timer selection and state classification
			assign sel = tsel_r[2*i +: 2];
			assign ok = {30'h0, sel} < N_TMR;
			assign cnt = ok ? tmr_count_in[{sel, 4'h0} +: 16] : 16'h0;
			assign pk = ok ? tmr_peak_in[{sel, 4'h0} +: 16] : 16'h0;
			assign ud = ok & tmr_updown_in[sel];
			assign tk = ok & tmr_tick_in[sel];
			assign zero = (cnt == `OCPR_CNT_ZERO);
			assign peak = (cnt == pk);
			assign down = ud & tmr_down_in[sel];

			// buffer transfers at zero and/or peak
			assign cbm = cbuf_r[2*i +: 2];
			assign tbm = tbuf_r[2*i +: 2];
			assign cxf = tk & ((cbm[0] & zero) | (cbm[1] & peak));
			assign txf = tk & ((tbm[0] & zero) | (tbm[1] & peak));
			assign cuse = (cbm == ocpr_buf_none || cxf) ? cmp_buf_r[i] : cmp_act_r;
			assign tuse = (tbm == ocpr_buf_none || txf) ? tbl_buf_r[i] : tbl_act_r;

			// match; top value is no peak match for an up-only timer
			assign mt[i] = (cnt == cuse) &
				~(~ud & peak & (cuse == `OCPR_CNT_TOP));

			// channel 1 switches table half on a channel 0 match
			if (i == 1) begin : g_t1
				assign t16 = mt[0] ? {tuse[`OCPR_TBL_XACT +: 12],
					tuse[3:0] | tuse[`OCPR_TBL_XFLG +: 4]} : tuse[15:0];
			end else begin : g_t0
				assign t16 = tuse[15:0];
			end

			assign dec = ocpr_decode(t16, zero, peak, down, mt[i]);
			assign act = run_r[i] & enh_r & tk;
			assign clr = wr_ctrl & ~hwdata_in[`OCPR_CTRL_FLAG + i];
			assign out_wr = wr_mode & ~run_r[i];
			assign out_nxt = out_wr ? hwdata_in[`OCPR_MODE_OUT + i] :
				act ? ocpr_apply(dec[1:0], out_r[i]) : out_r[i];
			assign flag_nxt = (act & dec[2]) | (flag_r[i] & ~clr);

			// channel state
			always_ff @(posedge clk_sys_in) begin
				if (!nrst_in) begin
					cmp_act_r <= `OCPR_RST_CMP;
					tbl_act_r <= `OCPR_RST_TBL;
					out_r[i] <= `OCPR_RST_OUT;
					flag_r[i] <= 1'b0;
					irq_r[i] <= 1'b0;
				end else begin
					if (cxf) cmp_act_r <= cmp_buf_r[i];
					if (txf) tbl_act_r <= tbl_buf_r[i];
					out_r[i] <= out_nxt;
					flag_r[i] <= flag_nxt;
					irq_r[i] <= flag_r[i] & ie_r[i];
				end
			end

			AST_STOP_OUT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
				!run_r[i] && !out_wr |=> out_r[i] == $past(out_r[i]))
				else $error("output moved while stopped");
			AST_RUN_NOWRITE: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
				run_r[i] && wr_mode && !tk |=> out_r[i] == $past(out_r[i]))
				else $error("level write took effect while running");
			AST_STOP_FLAG: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
				!run_r[i] && !clr |=> flag_r[i] == $past(flag_r[i]))
				else $error("flag moved while stopped");
			AST_IRQ: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
				##2 irq_r[i] == $past(flag_r[i] & ie_r[i], 1))
				else $error("interrupt differs from flag and enable");
			AST_INVERT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
				act && !out_wr && t16 == 16'h0fff && mt[i]
				|=> out_r[i] != $past(out_r[i]) && flag_r[i])
				else $error("match under 0x0fff did not invert and flag");
			AST_NOBUF: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
				cbm == ocpr_buf_none |-> cuse == cmp_buf_r[i])
				else $error("unbuffered compare not immediate");
			AST_ZERO_XFER: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
				tk && zero && cbm == ocpr_buf_zero ##1 cbm == ocpr_buf_zero && !tk
				|-> cuse == $past(cmp_buf_r[i]))
				else $error("compare not loaded at zero");
			AST_PEAK_XFER: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
				tk && peak && cbm == ocpr_buf_both |=> cmp_act_r == $past(cmp_buf_r[i]))
				else $error("compare not loaded at peak");
			AST_UP_TOP: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
				!ud && peak && cuse == `OCPR_CNT_TOP |-> !mt[i])
				else $error("top compare matched an up-only timer");
			AST_NO_DOWN: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
				!ud |-> !down)
				else $error("down state for an up-only timer");
		end
	endgenerate

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign hrdata_out = hrdata_r;
	assign hreadyout_out = hready_r;
	assign hresp_out = 1'b0;
	assign compare_output_out = out_r;
	assign irq_out = irq_r;

endmodule : ocpr_top

`default_nettype wire

// *** hw/ocpr_consts.svh ***
// Operation
// - a running channel in enhanced mode updates output and flag from its table and its timer's count
// - stopped: output level write kept and driven; running: writes ignored, live level read
// - match flag held while stopped, updated while running, clearable in both states
// - interrupt enables and compare values writable and effective in either state
// - compare behaviour depends on the selected timer's up or up/down mode
// - channel 0 uses a 16-bit table, channel 1 a 32-bit table with channel 0 terms
// - each count classified zero, up, peak or down with match, then actions applied
// - table 0x0FFF inverts output and sets flag on every match, holds on mismatch
// - compare buffer mode 00 makes a compare write effective at once
// - compare buffer mode 01 transfers the buffered value at count zero
// - compare buffer mode 11 transfers at count zero and at peak
// - up-count timer: compare 0xFFFF is no peak match, peak mismatch action used
// - up/down timer: compare 0xFFFF matches at peak and applies the peak match action
// - compare above the peak gives no match, output untouched by match actions
// - up-count timer never applies the down match or down mismatch actions
// - table 0x852D gives a symmetric high pulse with flag on the zero, up and down matches
// - table 0x852D with compare 0x0000 keeps the output high
// - one enhanced mode bit and the legacy selections are shared by both channels
`ifndef OCPR_CONSTS_SVH
`define OCPR_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OCPR_OFS_CTRL 8'h00
`define OCPR_OFS_MODE 8'h04
`define OCPR_OFS_CMP0 8'h08
`define OCPR_OFS_CMP1 8'h0c
`define OCPR_OFS_TBL0 8'h10
`define OCPR_OFS_TBL1 8'h14

// ----------------------------------------------------------------
// field positions (one bit per channel fields add the channel number, two bit ones twice it)
// ----------------------------------------------------------------
`define OCPR_CTRL_RUN 0
`define OCPR_CTRL_IE 4
`define OCPR_CTRL_FLAG 8
`define OCPR_MODE_ENH 0
`define OCPR_MODE_LEGA 1
`define OCPR_MODE_LEGB 2
`define OCPR_MODE_OUT 8
`define OCPR_MODE_TSEL 16
`define OCPR_MODE_CBUF 20
`define OCPR_MODE_TBUF 24

// action table fields: two bit actions, one bit flag sets
`define OCPR_TBL_MM_ZERO 14
`define OCPR_TBL_MM_PEAK 12
`define OCPR_TBL_M_ZERO 10
`define OCPR_TBL_M_UP 8
`define OCPR_TBL_M_PEAK 6
`define OCPR_TBL_M_DOWN 4
`define OCPR_TBL_F_ZERO 3
`define OCPR_TBL_F_UP 2
`define OCPR_TBL_F_PEAK 1
`define OCPR_TBL_F_DOWN 0
`define OCPR_TBL_XFLG 16
`define OCPR_TBL_XACT 20

// ----------------------------------------------------------------
// reset values and special counts
// ----------------------------------------------------------------
`define OCPR_RST_OUT 1'h0
`define OCPR_RST_ENH 1'h1
`define OCPR_RST_CMP 16'h0000
`define OCPR_RST_TBL 32'h0000_0000
`define OCPR_CNT_ZERO 16'h0000
`define OCPR_CNT_TOP 16'hffff

`endif

// *** hw/ocpr_pkg.sv ***
`default_nettype none
`include "ocpr_consts.svh"

package ocpr_pkg;

	// output action encoding of the action table
	typedef enum logic [1:0] {
		ocpr_act_hold = 2'h0,
		ocpr_act_set = 2'h1,
		ocpr_act_reset = 2'h2,
		ocpr_act_inv = 2'h3
	} ocpr_act_t;

	// compare / table buffer transfer modes
	typedef enum logic [1:0] {
		ocpr_buf_none = 2'h0,
		ocpr_buf_zero = 2'h1,
		ocpr_buf_peak = 2'h2,
		ocpr_buf_both = 2'h3
	} ocpr_buf_t;

	// table decode: returns {flag_set, action}
	function automatic logic [2:0] ocpr_decode(input logic [15:0] tbl, input logic zero,
		input logic peak, input logic down, input logic match);
		logic [2:0] res;
		res = 3'h0;
		if (zero) begin
			res = match ? {tbl[`OCPR_TBL_F_ZERO], tbl[`OCPR_TBL_M_ZERO +: 2]}
				: {1'b0, tbl[`OCPR_TBL_MM_ZERO +: 2]};
		end else if (peak) begin
			res = match ? {tbl[`OCPR_TBL_F_PEAK], tbl[`OCPR_TBL_M_PEAK +: 2]}
				: {1'b0, tbl[`OCPR_TBL_MM_PEAK +: 2]};
		end else if (down) begin
			res = match ? {tbl[`OCPR_TBL_F_DOWN], tbl[`OCPR_TBL_M_DOWN +: 2]} : 3'h0;
		end else begin
			res = match ? {tbl[`OCPR_TBL_F_UP], tbl[`OCPR_TBL_M_UP +: 2]} : 3'h0;
		end
		return res;
	endfunction : ocpr_decode

	// apply an output action to the current level
	function automatic logic ocpr_apply(input logic [1:0] act, input logic lvl);
		logic res;
		res = lvl;
		case (act)
			ocpr_act_set: res = 1'b1;
			ocpr_act_reset: res = 1'b0;
			ocpr_act_inv: res = ~lvl;
			default: res = lvl;
		endcase
		return res;
	endfunction : ocpr_apply

endpackage : ocpr_pkg

`default_nettype wire

// *** bench/ocpr_tmr_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// free running timer: up or up/down count, one tick every div_in+1 cycles
module ocpr_tmr_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// control
	input wire logic run_in,
	input wire logic updown_in,
	input wire logic [15:0] peak_in,
	input wire logic [3:0] div_in,
	// count side
	output logic [15:0] count_out,
	output logic down_out,
	output logic tick_out
);
	logic [3:0] pre_r;

	// prescaler and count; tick marks the one cycle that carries a fresh count
	always_ff @(posedge clk_in) begin
		tick_out <= 1'b0;
		if (!nrst_in) begin
			count_out <= 16'h0000;
			down_out <= 1'b0;
			pre_r <= 4'h0;
		end else if (run_in && pre_r < div_in) begin
			pre_r <= pre_r + 4'h1;
		end else if (run_in) begin
			pre_r <= 4'h0;
			tick_out <= 1'b1;
			if (updown_in) begin
				count_out <= down_out ? count_out - 16'h1 : count_out + 16'h1;
				down_out <= down_out ? (count_out != 16'h1) : (count_out + 16'h1 >= peak_in);
			end else begin
				count_out <= (count_out >= peak_in) ? 16'h0000 : count_out + 16'h1;
				down_out <= 1'b0;
			end
		end
	end
endmodule : ocpr_tmr_model

`default_nettype wire

// *** bench/ocpr_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ocpr_consts.svh"

module ocpr_top_tb;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic hreadyout;
	logic hresp;
	wire logic [47:0] tcnt;
	logic [47:0] tpk = 48'h0;
	wire logic [2:0] tdn;
	wire logic [2:0] ttick;
	logic [2:0] trun = 3'h0;
	logic [2:0] tud = 3'h0;
	logic [1:0] cout;
	logic [1:0] irq;
	int n_fail = 0;
	int tests_run = 0;

	// clock
	always #25 clk_sys_in = ~clk_sys_in;

	// ----------------------------------------------------------------
	// design and timers
	// ----------------------------------------------------------------
	ocpr_top #(.N_TMR(3)) ocpr_top_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
		.hreadyout_out(hreadyout), .hresp_out(hresp), .tmr_count_in(tcnt),
		.tmr_peak_in(tpk), .tmr_updown_in(tud), .tmr_down_in(tdn), .tmr_tick_in(ttick),
		.compare_output_out(cout), .irq_out(irq));

	// timer 0 ticks every cycle, the others every fourth
	for (genvar g = 0; g < 3; g++) begin : g_tmr
		ocpr_tmr_model ocpr_tmr_model_inst (.clk_in(clk_sys_in), .nrst_in(nrst_in),
			.run_in(trun[g]), .updown_in(tud[g]), .peak_in(tpk[g*16 +: 16]),
			.div_in(g == 0 ? 4'h0 : 4'h3), .count_out(tcnt[g*16 +: 16]),
			.down_out(tdn[g]), .tick_out(ttick[g]));
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic close_out;
		$display("counts: %0d mismatches in %0d comparisons", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic hang(input string what);
		n_fail++;
		$display("mismatch at %0t: %s timed out", $time, what);
		close_out();
	endtask : hang

	// wait for hready high at a rising edge, bounded
	task automatic rdy;
		int k;
		k = 0;
		do begin
			@(posedge clk_sys_in);
			k++;
		end while (hreadyout !== 1'b1 && k < 40);
		if (k >= 40) hang("bus");
	endtask : rdy

	// one single word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_sys_in);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0, "okay");
	endtask : bus

	// wait for a tick of timer t at count v and direction d, then one more cycle
	task automatic wcnt(input int t, input logic [15:0] v, input logic d);
		int k;
		k = 0;
		do begin
			@(negedge clk_sys_in);
			k++;
		end while (!(ttick[t] === 1'b1 && tcnt[t*16 +: 16] === v && tdn[t] === d) && k < 400);
		if (k >= 400) hang("timer");
		@(negedge clk_sys_in);
	endtask : wcnt

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic sc_reset;
		bus(0, `OCPR_OFS_CTRL, 32'h0);
		chk(rd, 32'h0, "ctrl");
		bus(0, `OCPR_OFS_MODE, 32'h0);
		chk(rd, 32'h1, "mode");
		chk({30'h0, cout}, 32'h0, "out");
		bus(1, 8'h40, 32'hffff_ffff);
		bus(0, 8'h40, 32'h0);
		chk(rd, 32'h0, "unmapped");
		bus(1, `OCPR_OFS_MODE, 32'h0000_0301);
		// the level lands at the edge that ends the data phase
		@(negedge clk_sys_in);
		chk({30'h0, cout}, 32'h3, "level");
		bus(0, `OCPR_OFS_MODE, 32'h0);
		chk(rd, 32'h0000_0301, "mode");
		bus(1, `OCPR_OFS_MODE, 32'h0000_0001);
		@(negedge clk_sys_in);
		chk({30'h0, cout}, 32'h0, "level");
	endtask : sc_reset

	// channel 0, up count, invert on every match, no buffer
	task automatic sc_invert;
		tpk[15:0] <= 16'h000f;
		trun[0] <= 1'b1;
		bus(1, `OCPR_OFS_CMP0, 32'h5);
		bus(1, `OCPR_OFS_TBL0, 32'h0fff);
		bus(1, `OCPR_OFS_CTRL, 32'h11);
		wcnt(0, 16'h5, 1'b0);
		chk({31'h0, cout[0]}, 32'h1, "inv");
		bus(0, `OCPR_OFS_CTRL, 32'h0);
		chk(rd, 32'h111, "flag");
		chk({31'h0, irq[0]}, 32'h1, "irq");
		wcnt(0, 16'h5, 1'b0);
		chk({31'h0, cout[0]}, 32'h0, "inv");
		bus(1, `OCPR_OFS_CTRL, 32'h1);
		bus(0, `OCPR_OFS_CTRL, 32'h0);
		chk(rd, 32'h1, "clear");
		chk({31'h0, irq[0]}, 32'h0, "irq");
		wcnt(0, 16'h5, 1'b0);
		bus(1, `OCPR_OFS_MODE, 32'h0000_0001);
		@(negedge clk_sys_in);
		chk({30'h0, cout}, 32'h1, "level");
		bus(0, `OCPR_OFS_MODE, 32'h0);
		chk(rd, 32'h0000_0101, "live");
		bus(1, `OCPR_OFS_CMP0, 32'h14);
		wcnt(0, 16'h000f, 1'b0);
		wcnt(0, 16'h000f, 1'b0);
		chk({31'h0, cout[0]}, 32'h1, "above");
		bus(1, `OCPR_OFS_CTRL, 32'h100);
		bus(1, `OCPR_OFS_CMP0, 32'h5);
		wcnt(0, 16'h5, 1'b0);
		chk({31'h0, cout[0]}, 32'h1, "stop");
		bus(0, `OCPR_OFS_CTRL, 32'h0);
		chk(rd, 32'h100, "hold");
	endtask : sc_invert

	// channel 1 on timer 1, up/down, pulse table, compare buffered to zero
	task automatic sc_pulse;
		tpk[31:16] <= 16'h000c;
		tud[1] <= 1'b1;
		trun[1] <= 1'b1;
		bus(1, `OCPR_OFS_MODE, 32'h0044_0101);
		bus(1, `OCPR_OFS_TBL1, 32'h8520_852d);
		bus(1, `OCPR_OFS_CTRL, 32'h2);
		wcnt(1, 16'h0, 1'b0);
		chk({31'h0, cout[1]}, 32'h1, "zero");
		bus(1, `OCPR_OFS_CMP1, 32'h4);
		wcnt(1, 16'h4, 1'b1);
		chk({31'h0, cout[1]}, 32'h1, "buf");
		wcnt(1, 16'h0, 1'b0);
		chk({31'h0, cout[1]}, 32'h0, "zero");
		wcnt(1, 16'h4, 1'b0);
		chk({31'h0, cout[1]}, 32'h1, "up");
		bus(0, `OCPR_OFS_CTRL, 32'h0);
		chk(rd, 32'h202, "flag");
		wcnt(1, 16'h4, 1'b1);
		chk({31'h0, cout[1]}, 32'h0, "down");
	endtask : sc_pulse

	// channel 0 on timer 1, compare buffered to zero and peak, then legacy mode holds
	task automatic sc_peak;
		bus(1, `OCPR_OFS_CTRL, 32'h0);
		bus(1, `OCPR_OFS_MODE, 32'h0035_0001);
		bus(1, `OCPR_OFS_CMP0, 32'ha);
		wcnt(1, 16'h000c, 1'b1);
		bus(1, `OCPR_OFS_CTRL, 32'h1);
		wcnt(1, 16'h2, 1'b0);
		chk({31'h0, cout[0]}, 32'h1, "down");
		// a write during the up slope must be compared on the down slope
		bus(1, `OCPR_OFS_CMP0, 32'h7);
		wcnt(1, 16'h7, 1'b1);
		chk({31'h0, cout[0]}, 32'h1, "peak");
		bus(1, `OCPR_OFS_CTRL, 32'h0);
		bus(1, `OCPR_OFS_MODE, 32'h0035_0000);
		bus(1, `OCPR_OFS_CTRL, 32'h1);
		wcnt(1, 16'h7, 1'b1);
		chk({31'h0, cout[0]}, 32'h0, "legacy");
		bus(0, `OCPR_OFS_CTRL, 32'h0);
		chk(rd, 32'h1, "legacy");
	endtask : sc_peak

	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		sc_reset();
		sc_invert();
		sc_pulse();
		sc_peak();
		close_out();
	end
endmodule : ocpr_top_tb

`default_nettype wire
